/* File: logic/uie_in_endpoint.sv */
// control and status logic for usb in endpoints behind an indexed register file
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module uie_in_endpoint
    import uie_pkg::*;
#(
    parameter int NUM_EP = 2
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // register port
    input wire logic [5:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // packet engine events, qualified by EP_SEL except SOF_RCVD
    input wire logic [3:0] EP_SEL,
    input wire logic IN_TOKEN,
    input wire logic PKT_SENT,
    input wire logic ACK_RCVD,
    input wire logic STALL_SENT,
    input wire logic SOF_RCVD,
    // per-endpoint state towards the packet engine
    output logic [NUM_EP-1:0] PKT_AVAIL,
    output logic [NUM_EP-1:0] SEND_ZLP,
    output logic [NUM_EP-1:0] SEND_NAK,
    output logic [NUM_EP-1:0] DATA_PID1,
    output logic [NUM_EP-1:0] EP_IS_IN,
    output logic [NUM_EP-1:0] FIFO_UPPER,
    output logic [NUM_EP-1:0] EP_IRQ
);
    initial begin
        if (NUM_EP < 1 || NUM_EP > 15) begin
            $error("NUM_EP out of range");
        end
        // the flush counter is two bits wide
        if (UIE_FLUSH_CYC < 1 || UIE_FLUSH_CYC > 4) begin
            $error("flush time does not fit the flush counter");
        end
    end

    logic [3:0] index_ff;
    logic [7:0] high_ff [NUM_EP];
    logic [1:0] cnt_ff [NUM_EP];
    logic [NUM_EP-1:0] prdy_ff;
    logic [NUM_EP-1:0] hide_ff;
    logic [NUM_EP-1:0] undrn_ff;
    logic [NUM_EP-1:0] stl_ff;
    logic [NUM_EP-1:0] tgl_ff;
    logic [NUM_EP-1:0] flreq_ff;
    uie_fl_state_t fl_st_ff [NUM_EP];
    logic [1:0] fl_cnt_ff [NUM_EP];
    logic [7:0] low_rd [NUM_EP];

    // endpoint index register; endpoint n maps to index n, held in slot n-1
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            index_ff <= 4'h0;
        end else if (WR && ADDR == UIE_ADDR_INDEX) begin
            index_ff <= WDATA[3:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            logic sel; // register access hits this endpoint
            logic ev; // packet engine event for this endpoint
            logic wl;
            logic wh;
            logic dbuf;
            logic iso;
            logic split;
            logic ftgl;
            logic flush_done;
            logic flush_go;
            logic load;
            logic sent;
            logic [1:0] cap;
            logic drop; // flush completion takes one packet
            logic irq_go; // a send that takes the ready flag down or empties the fifo
            logic [1:0] nxt_cnt;
            logic nxt_prdy;
            logic nxt_tgl;
            logic [7:0] low_img;
            assign sel = (index_ff == 4'(g + 1));
            assign ev = (EP_SEL == 4'(g + 1));
            assign wl = WR && sel && ADDR == UIE_ADDR_CTRL_LOW;
            assign wh = WR && sel && ADDR == UIE_ADDR_CTRL_HIGH;
            assign dbuf = high_ff[g][UIE_HIGH_DBUF];
            assign iso = high_ff[g][UIE_HIGH_ISO];
            assign split = high_ff[g][UIE_HIGH_SPLIT];
            assign ftgl = high_ff[g][UIE_HIGH_FTGL];
            assign cap = dbuf ? 2'd2 : 2'd1;
            assign sent = ev && PKT_SENT && cnt_ff[g] != 2'd0;
            assign flush_done = fl_st_ff[g] == UIE_FL_DONE;
            assign flush_go = wl && WDATA[UIE_LOW_FLUSH];
            // a load is a firmware ready write while room remains
            assign load = wl && WDATA[UIE_LOW_PRDY] && !prdy_ff[g] && cnt_ff[g] < cap;
            assign drop = flush_done && cnt_ff[g] != 2'd0 && !sent;
            assign irq_go = sent && (prdy_ff[g] || cnt_ff[g] == 2'd1);

            // high control register, only writable bits stored
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    high_ff[g] <= UIE_HIGH_RESET;
                end else if (wh) begin
                    high_ff[g] <= WDATA & UIE_HIGH_WMASK;
                end
            end

            // next packet count: a stall empties the fifo, otherwise load adds
            // and send or flush take one away; a flush racing a send drops nothing
            always_comb begin
                nxt_cnt = cnt_ff[g];
                if (ev && STALL_SENT) begin
                    nxt_cnt = 2'd0;
                end else begin
                    nxt_cnt = cnt_ff[g] + 2'(load) - 2'(sent) - 2'(drop);
                end
            end

            // packet count in the fifo
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    cnt_ff[g] <= 2'd0;
                end else begin
                    cnt_ff[g] <= nxt_cnt;
                end
            end

            // packet ready: set by firmware, cleared when taken or slot open
            always_comb begin
                nxt_prdy = prdy_ff[g];
                if ((ev && STALL_SENT) || flush_done) begin
                    nxt_prdy = 1'b0;
                end else if (load) begin
                    // with a second slot free the flag drops at once
                    nxt_prdy = !(dbuf && cnt_ff[g] == 2'd0);
                end else if (sent) begin
                    nxt_prdy = 1'b0;
                end else if (dbuf && prdy_ff[g] && cnt_ff[g] < cap) begin
                    nxt_prdy = 1'b0;
                end
            end

            // ready flag register
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    prdy_ff[g] <= 1'b0;
                end else begin
                    prdy_ff[g] <= nxt_prdy;
                end
            end

            // update-on-frame hides the ready flag until the next sof
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    hide_ff[g] <= 1'b0;
                end else if (SOF_RCVD) begin
                    hide_ff[g] <= 1'b0;
                end else if (wl && WDATA[UIE_LOW_PRDY] && iso && WDATA[1]) begin
                    hide_ff[g] <= 1'b1;
                end
            end

            // underrun: set wins over firmware clear
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    undrn_ff[g] <= 1'b0;
                end else if (ev && IN_TOKEN && cnt_ff[g] == 2'd0) begin
                    undrn_ff[g] <= 1'b1;
                end else if (wl && !WDATA[UIE_LOW_UNDRN]) begin
                    undrn_ff[g] <= 1'b0;
                end
            end

            // sent-stall flag, set wins over clear
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    stl_ff[g] <= 1'b0;
                end else if (ev && STALL_SENT) begin
                    stl_ff[g] <= 1'b1;
                end else if (wl && !WDATA[UIE_LOW_STLSNT]) begin
                    stl_ff[g] <= 1'b0;
                end
            end

            // data toggle sequencing; a clear write beats a same-cycle flip
            always_comb begin
                nxt_tgl = tgl_ff[g];
                if (wl && WDATA[UIE_LOW_CLRTG]) begin
                    nxt_tgl = 1'b0;
                end else if (ftgl && sent) begin
                    nxt_tgl = !tgl_ff[g];
                end else if (!ftgl && ev && ACK_RCVD) begin
                    nxt_tgl = !tgl_ff[g];
                end
            end

            // toggle register
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    tgl_ff[g] <= 1'b0;
                end else begin
                    tgl_ff[g] <= nxt_tgl;
                end
            end

            // low register image; clear-toggle and the spare bits 4 and 7 read zero
            always_comb begin
                low_img = 8'h00;
                low_img[UIE_LOW_PRDY] = prdy_ff[g] && !hide_ff[g];
                low_img[UIE_LOW_NEMPTY] = cnt_ff[g] != 2'd0;
                low_img[UIE_LOW_UNDRN] = undrn_ff[g];
                low_img[UIE_LOW_FLUSH] = flreq_ff[g];
                low_img[UIE_LOW_STLSNT] = stl_ff[g];
            end
            assign low_rd[g] = low_img;

            // flush sequencer: bit reads 1 until the fixed flush time passes
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    fl_st_ff[g] <= UIE_FL_IDLE;
                    fl_cnt_ff[g] <= 2'd0;
                    flreq_ff[g] <= 1'b0;
                end else begin
                    case (fl_st_ff[g])
                        UIE_FL_IDLE: begin
                            if (flush_go) begin
                                fl_st_ff[g] <= UIE_FL_BUSY;
                                fl_cnt_ff[g] <= 2'(UIE_FLUSH_CYC - 1);
                                flreq_ff[g] <= 1'b1;
                            end
                        end
                        UIE_FL_BUSY: begin
                            if (fl_cnt_ff[g] == 2'd0) begin
                                fl_st_ff[g] <= UIE_FL_DONE;
                            end else begin
                                fl_cnt_ff[g] <= fl_cnt_ff[g] - 2'd1;
                            end
                        end
                        UIE_FL_DONE: begin
                            fl_st_ff[g] <= UIE_FL_IDLE;
                            flreq_ff[g] <= 1'b0;
                        end
                        default: begin
                            fl_st_ff[g] <= UIE_FL_IDLE;
                            flreq_ff[g] <= 1'b0;
                        end
                    endcase
                end
            end

            // fifo state towards the packet engine
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    PKT_AVAIL[g] <= 1'b0;
                    SEND_ZLP[g] <= 1'b0;
                    SEND_NAK[g] <= 1'b0;
                end else begin
                    PKT_AVAIL[g] <= cnt_ff[g] != 2'd0;
                    SEND_ZLP[g] <= iso && cnt_ff[g] == 2'd0;
                    SEND_NAK[g] <= !iso && cnt_ff[g] == 2'd0;
                end
            end

            // configuration and toggle towards the packet engine
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    DATA_PID1[g] <= 1'b0;
                    EP_IS_IN[g] <= 1'b0;
                    FIFO_UPPER[g] <= 1'b0;
                end else begin
                    // direction only matters while the fifo is whole
                    DATA_PID1[g] <= tgl_ff[g];
                    EP_IS_IN[g] <= split || high_ff[g][UIE_HIGH_DIR];
                    FIFO_UPPER[g] <= split;
                end
            end

            // interrupt pulse; one cycle, since its cause is one cycle too
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    EP_IRQ[g] <= 1'b0;
                end else begin
                    EP_IRQ[g] <= irq_go;
                end
            end
        end
    endgenerate

    // read mux, data valid the cycle after the strobe
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (ADDR == UIE_ADDR_INDEX) begin
            rd_mux = {4'h0, index_ff};
        end
        for (int i = 0; i < NUM_EP; i++) begin
            if (index_ff == 4'(i + 1)) begin
                if (ADDR == UIE_ADDR_CTRL_HIGH) begin
                    rd_mux = high_ff[i];
                end else if (ADDR == UIE_ADDR_CTRL_LOW) begin
                    rd_mux = low_rd[i];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= rd_mux;
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule

/* File: logic/uie_pkg.sv */
// constants for the usb in endpoint control block
package uie_pkg;
    // register indices (indexed usb register file)
    localparam logic [5:0] UIE_ADDR_CTRL_LOW = 6'h11;
    localparam logic [5:0] UIE_ADDR_CTRL_HIGH = 6'h12;
    localparam logic [5:0] UIE_ADDR_INDEX = 6'h0E;
    localparam logic [5:0] UIE_ADDR_STATUS = 6'h13;
    // control low bit positions
    localparam int UIE_LOW_PRDY = 0;
    localparam int UIE_LOW_NEMPTY = 1;
    localparam int UIE_LOW_UNDRN = 2;
    localparam int UIE_LOW_FLUSH = 3;
    localparam int UIE_LOW_STLSNT = 5;
    localparam int UIE_LOW_CLRTG = 6;
    // control high bit positions
    localparam int UIE_HIGH_DBUF = 7;
    localparam int UIE_HIGH_ISO = 6;
    localparam int UIE_HIGH_DIR = 5;
    localparam int UIE_HIGH_FTGL = 3;
    localparam int UIE_HIGH_SPLIT = 2;
    // writable bits of the high register; bits 4 and 1:0 read zero
    localparam logic [7:0] UIE_HIGH_WMASK = 8'hEC;
    localparam logic [7:0] UIE_HIGH_RESET = 8'h00;
    localparam logic [7:0] UIE_LOW_RESET = 8'h00;
    // flush completes after this many ns, rounded up to whole clock cycles
    localparam int UIE_FLUSH_NS = 20;
    localparam int UIE_CLK_NS = 10;
    localparam int UIE_FLUSH_CYC = (UIE_FLUSH_NS + UIE_CLK_NS - 1) / UIE_CLK_NS;
    // flush sequencer states
    typedef enum logic [1:0] {
        UIE_FL_IDLE = 2'b00,
        UIE_FL_BUSY = 2'b01,
        UIE_FL_DONE = 2'b10
    } uie_fl_state_t;
endpackage

/* File: tb/testbench.sv */
// self-checking testbench for the usb in endpoint control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module testbench;
    import uie_pkg::*;
    localparam int NUM_EP = 2;
    localparam logic [5:0] LO = UIE_ADDR_CTRL_LOW;
    localparam logic [5:0] HI = UIE_ADDR_CTRL_HIGH;
    logic CLK, RST_B, WR, RD, IN_TOKEN, PKT_SENT, ACK_RCVD, STALL_SENT, SOF_RCVD;
    logic [5:0] ADDR;
    logic [7:0] WDATA, RDATA;
    logic [3:0] EP_SEL;
    logic [NUM_EP-1:0] PKT_AVAIL, SEND_ZLP, SEND_NAK, DATA_PID1;
    logic [NUM_EP-1:0] EP_IS_IN, FIFO_UPPER, EP_IRQ;
    int err_count, samples_checked;
    int irq_n = 0;
    uie_in_endpoint #(.NUM_EP(NUM_EP)) i_uie_in_endpoint (.*);
    uie_host_model #(.NUM_EP(NUM_EP)) i_uie_host_model (.*);
    // 100 MHz clock
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // count endpoint 1 interrupt pulses
    always @(posedge CLK) begin
        if (EP_IRQ[0] === 1'b1)
            irq_n <= irq_n + 1;
    end
    // register bus cycles; a gap cycle keeps strobes from merging
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rdv(input logic [5:0] a, output logic [7:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        v = RDATA;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] v;
        rdv(a, v);
        `CHK("rdata", e, v)
    endtask
    // outputs lag the stored state by one cycle
    task automatic settle();
        repeat (2) @(posedge CLK);
        #1;
    endtask
    // flush, then poll the self-clearing bit under a bound
    task automatic flush(input logic [7:0] e);
        logic [7:0] v;
        wr(LO, 8'h08);
        for (int i = 0; i < 8; i++) begin
            rdv(LO, v);
            if (v[UIE_LOW_FLUSH] === 1'b0)
                break;
        end
        `CHK("flush low", e, v)
        if (v[UIE_LOW_FLUSH] !== 1'b0)
            results();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // reset, then one pass over the endpoint behaviours
    initial begin
        {RST_B, WR, RD, ADDR, WDATA} = '0;
        err_count = 0;
        samples_checked = 0;
        repeat (12) @(posedge CLK);
        RST_B <= 1'b1;
        wr(UIE_ADDR_INDEX, 8'h01);
        rd(HI, 8'h00);
        rd(LO, 8'h00);
        wr(HI, 8'hFF);
        rd(HI, 8'hEC);
        settle();
        `CHK("split upper", 1'b1, FIFO_UPPER[0])
        wr(HI, 8'h20);
        settle();
        `CHK("dir in", 1'b1, EP_IS_IN[0])
        `CHK("unsplit", 1'b0, FIFO_UPPER[0])
        wr(HI, 8'h00);
        settle();
        `CHK("dir out", 1'b0, EP_IS_IN[0])
        $display("config test done");
        for (int m = 0; m < 2; m++) begin
            wr(HI, m ? 8'h40 : 8'h00);
            settle();
            `CHK("zlp", m[0], SEND_ZLP[0])
            i_uie_host_model.xfer(4'h1, 1'b1);
            rd(LO, 8'h04);
            rd(LO, 8'h04);
            wr(LO, 8'h00);
            rd(LO, 8'h00);
        end
        $display("underrun test done");
        wr(HI, 8'h00);
        wr(LO, 8'h01);
        rd(LO, 8'h03);
        i_uie_host_model.xfer(4'h1, 1'b1);
        rd(LO, 8'h00);
        `CHK("irq count", 1, irq_n)
        `CHK("pid ack", 1'b1, DATA_PID1[0])
        wr(LO, 8'h01);
        i_uie_host_model.xfer(4'h1, 1'b0);
        settle();
        `CHK("pid no ack", 1'b1, DATA_PID1[0])
        wr(HI, 8'h08);
        flush(8'h00);
        wr(LO, 8'h01);
        i_uie_host_model.xfer(4'h1, 1'b0);
        settle();
        `CHK("pid forced", 1'b0, DATA_PID1[0])
        wr(LO, 8'h01);
        i_uie_host_model.xfer(4'h1, 1'b0);
        settle();
        `CHK("pid forced 2", 1'b1, DATA_PID1[0])
        wr(LO, 8'h40);
        settle();
        `CHK("pid cleared", 1'b0, DATA_PID1[0])
        $display("toggle test done");
        flush(8'h00);
        wr(HI, 8'h80);
        wr(LO, 8'h01);
        rd(LO, 8'h02);
        wr(LO, 8'h01);
        rd(LO, 8'h03);
        flush(8'h02);
        flush(8'h00);
        wr(HI, 8'h40);
        wr(LO, 8'h03);
        rd(LO, 8'h02);
        i_uie_host_model.ev(4'h0, 5'h10);
        rd(LO, 8'h03);
        wr(HI, 8'h00);
        i_uie_host_model.ev(4'h1, 5'h08);
        rd(LO, 8'h20);
        wr(LO, 8'h00);
        $display("flush and stall test done");
        wr(UIE_ADDR_INDEX, 8'h02);
        wr(HI, 8'h80);
        i_uie_host_model.xfer(4'h2, 1'b1);
        rd(LO, 8'h04);
        wr(UIE_ADDR_INDEX, 8'h01);
        rd(HI, 8'h00);
        rd(LO, 8'h00);
        rd(UIE_ADDR_STATUS, 8'h00);
        $display("index test done");
        results();
    end
endmodule

/* File: tb/uie_host_model.sv */
// host side model issuing endpoint events to the in endpoint block
`timescale 1ns/1ps
module uie_host_model #(
    parameter int NUM_EP = 2
) (
    // clock and endpoint state seen by the host side
    input wire logic CLK,
    input wire logic [NUM_EP-1:0] PKT_AVAIL,
    // token and handshake events
    output logic [3:0] EP_SEL,
    output logic IN_TOKEN, PKT_SENT, ACK_RCVD, STALL_SENT, SOF_RCVD
);
    // idle selects no endpoint so a stray pulse other than sof hits nothing
    initial begin
        EP_SEL = 4'h0;
        {SOF_RCVD, STALL_SENT, ACK_RCVD, PKT_SENT, IN_TOKEN} = 5'h00;
    end
    // one-cycle event; k is sof, stall, ack, sent, token
    task automatic ev(input logic [3:0] ep, input logic [4:0] k);
        @(posedge CLK);
        EP_SEL <= ep;
        {SOF_RCVD, STALL_SENT, ACK_RCVD, PKT_SENT, IN_TOKEN} <= k;
        @(posedge CLK);
        EP_SEL <= 4'h0;
        {SOF_RCVD, STALL_SENT, ACK_RCVD, PKT_SENT, IN_TOKEN} <= 5'h00;
    endtask
    // in transaction: data only when a packet waits, ack only after data
    task automatic xfer(input logic [3:0] ep, input logic ack);
        ev(ep, 5'h01);
        #1;
        if (PKT_AVAIL[ep - 4'h1] === 1'b1) begin
            ev(ep, 5'h02);
            if (ack)
                ev(ep, 5'h04);
        end
    endtask
endmodule

/* File: tb/uie_in_endpoint_chk.sv */
// assertion checker for the usb in endpoint control block
`timescale 1ns/1ps
module uie_in_endpoint_chk
    import uie_pkg::*;
#(
    parameter int NUM_EP = 2
) (
    // clock, reset and register port
    input wire logic CLK, RST_B, WR, RD,
    input wire logic [5:0] ADDR,
    input wire logic [7:0] WDATA, RDATA,
    // packet engine events
    input wire logic [3:0] EP_SEL,
    input wire logic IN_TOKEN, PKT_SENT, ACK_RCVD, STALL_SENT, SOF_RCVD,
    // endpoint state
    input wire logic [NUM_EP-1:0] PKT_AVAIL, SEND_ZLP, SEND_NAK, DATA_PID1,
    input wire logic [NUM_EP-1:0] EP_IS_IN, FIFO_UPPER, EP_IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // endpoint 1 events; endpoint 1 exists for every NUM_EP
    logic sent1;
    logic stall1;
    logic ev1;
    assign sent1 = PKT_SENT && (EP_SEL == 4'h1);
    assign stall1 = STALL_SENT && (EP_SEL == 4'h1);
    assign ev1 = WR || (EP_SEL == 4'h1 && (PKT_SENT || ACK_RCVD));
    // the irq register adds a stage, so allow one or two cycles back
    sequence s_send_seen;
        $past(sent1) || $past(sent1, 2);
    endsequence
    a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside a read");
    a_high_unused: assert property ($past(RD) && $past(ADDR) == UIE_ADDR_CTRL_HIGH
        |-> (RDATA & 8'h13) == 8'h00) else $error("unused high bits read nonzero");
    a_clrtg_reads0: assert property ($past(RD) && $past(ADDR) == UIE_ADDR_CTRL_LOW
        |-> !RDATA[UIE_LOW_CLRTG]) else $error("clear toggle bit read one");
    a_split_is_in: assert property ((FIFO_UPPER & ~EP_IS_IN) == '0)
        else $error("split endpoint not in");
    a_answer_mode: assert property ((SEND_ZLP & SEND_NAK) == '0)
        else $error("zlp and nak together");
    a_avail_excl: assert property ((PKT_AVAIL & (SEND_ZLP | SEND_NAK)) == '0)
        else $error("empty answer while packet held");
    a_irq_cause: assert property (EP_IRQ[0] |-> s_send_seen)
        else $error("irq without a send");
    a_irq_single: assert property (EP_IRQ[0] |=> !EP_IRQ[0])
        else $error("irq longer than one cycle");
    a_pid_cause: assert property ($changed(DATA_PID1[0]) |-> $past(ev1) || $past(ev1, 2))
        else $error("toggle changed without cause");
    a_avail_cause: assert property ($rose(PKT_AVAIL[0]) |-> $past(WR) || $past(WR, 2))
        else $error("packet appeared without a write");
    a_stall_flush: assert property (stall1 |-> ##[1:3] !PKT_AVAIL[0])
        else $error("stall did not flush");
endmodule
bind uie_in_endpoint uie_in_endpoint_chk #(.NUM_EP(NUM_EP)) i_uie_in_endpoint_chk (.*);
